// File: logic/atas_cfg.svh
`ifndef ATAS_CFG_SVH
`define ATAS_CFG_SVH
// Opcodes carried by the task file command byte
`define ATAS_OP_RD_MULT 8'hC4
`define ATAS_OP_WR_MULT 8'hC5
`define ATAS_OP_SET_MULT 8'hC6
`define ATAS_OP_WR_VFY 8'h3C
`define ATAS_OP_WR_BUF 8'hE8
// Long bit position inside the write sector opcode
`define ATAS_LONG_BIT 1
// Sector geometry in 16-bit words, and the sector count that a zero count stands for
`define ATAS_SECT_WORDS 9'h100
`define ATAS_WORDS_LOG2 8
`define ATAS_SECT_ZERO 9'h100
// Supported block sizes lie between these powers of two
`define ATAS_BLK_MIN 8'h02
`define ATAS_BLK_MAX 8'h10
// Clock cycles per step of the data-in strobe; each half period takes two steps
`define ATAS_UDMA_DIV 4'h4
`endif

// File: logic/atas_pkg.sv
package atas_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_CHECK = 5'b00010,
      ST_XFER = 5'b00100,
      ST_MEDIA = 5'b01000,
      ST_DONE = 5'b10000
   } atas_state_e;
   typedef enum logic [2:0] {
      K_BAD, K_RDMA, K_WDMA, K_RMULT, K_WMULT, K_SETM, K_WSEC, K_WBUF
   } atas_kind_e;
   typedef enum logic [1:0] {MOP_READ, MOP_WRITE, MOP_VERIFY, MOP_BUFFER} atas_mop_e;
   typedef struct packed {
      logic bsy;
      logic drq;
      logic err;
      logic abrt;
   } atas_stat_s;
   typedef struct packed {
      atas_mop_e op;
      logic longMode;
   } atas_mreq_s;
endpackage : atas_pkg

// File: logic/atas_sequencer.sv
`timescale 1ns/10ps
`include "atas_cfg.svh"

// ****************************************
// Word buffer between host and media
// ****************************************
module atas_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic flush,
   input wire logic [W-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [W-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] count_q;
   logic [AW:0] countD;
   logic push;
   logic pop;

   // Handshakes and fill level
   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   assign countD = count_q + (AW+1)'(push) - (AW+1)'(pop);
   assign outData = mem[rdPtr_q];

   // Storage array, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   // Pointers and registered full/empty flags
   always_ff @(posedge clk) begin
      if (srst || flush) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
         inReady <= 1'b1;
         outValid <= 1'b0;
      end else begin
         if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         count_q <= countD;
         inReady <= countD != (AW+1)'(DEPTH);
         outValid <= countD != '0;
      end
   end
endmodule : atas_fifo

// Overview of operation
// [R01] DMA words paced by DMARQ; one ending interrupt
// [R02] Ultra read: place word, then toggle strobe
// [R03] DMA read error: send prior sectors only
// [R04] Read multiple: DRQ per block, no inner interrupts
// [R05] Whole blocks first, then remainder block
// [R06] Multiple commands abort when not enabled
// [R07] Read multiple error: still transfer block
// [R08] Zero block size disables, no error
// [R09] Reset disables multiple commands
// [R10] Sizes 2,4,8,16 set block and enable
// [R11] Other nonzero size aborts and disables
// [R12] Sector write count zero means 256
// [R13] First write buffer fill: DRQ, no interrupt
// [R14] Buffer full: DRQ low, BSY high, write
// [R15] Address tracks last sector; later sectors interrupt
// [R16] Write error stops, failing address kept
// [R17] Long write passes check bytes unchanged
// [R18] Write verify rereads each sector, reports errors
// [R19] Buffer write: DRQ plus interrupt, 256 words
// [R20] Write multiple: BSY at once, long ignored
// [R21] Write multiple error ends at failing sector
// [R22] Write multiple interrupts at each block DRQ
// [R23] Status read, command write, reset clear interrupt
module atas_sequencer #(
   parameter logic [7:0] RD_DMA_OP = 8'h01,
   parameter logic [7:0] WR_DMA_OP = 8'h02,
   parameter logic [7:0] WR_SEC_OP = 8'h04,
   parameter int FIFO_DEPTH = 8,
   parameter int LBA_W = 28
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic softReset,
   input wire logic cmdWrite,
   input wire logic [7:0] cmdCode,
   input wire logic [7:0] cmdCount,
   input wire logic [LBA_W-1:0] cmdAddr,
   input wire logic statusRead,
   input wire logic udmaMode,
   input wire logic hostStrobeN,
   input wire logic dmackN,
   input wire logic [15:0] ddIn,
   output logic [15:0] ddOut,
   output logic ddOe,
   output logic dmarq,
   output logic dStrobe,
   output atas_pkg::atas_stat_s status,
   output logic multEnabled,
   output logic [4:0] blockSize,
   output logic irq,
   output logic [LBA_W-1:0] taskAddr,
   output logic mediaReq,
   output atas_pkg::atas_mreq_s mediaCmd,
   output logic [LBA_W-1:0] mediaAddr,
   input wire logic mediaStat,
   input wire logic mediaErr,
   input wire logic [15:0] mediaRdData,
   input wire logic mediaRdValid,
   output logic mediaRdReady,
   output logic [15:0] mediaWrData,
   output logic mediaWrValid,
   input wire logic mediaWrReady
);
   import atas_pkg::*;

   logic rst;
   logic [17:0] pinS1_q;
   logic [17:0] pinS2_q;
   logic strbPrev_q;
   atas_state_e state_q;
   atas_kind_e kind_q;
   atas_kind_e kindNow;
   logic long_q, vfy_q, readDir_q, dma_q, stop_q, errF_q, abrt_q, irqEvt_q, mActive_q;
   logic [7:0] cnt_q;
   logic [8:0] remain_q, reqLeft_q, mWords_q, blkN;
   logic [16:0] hostWords_q;
   logic [LBA_W-1:0] curAddr_q;
   logic [3:0] udmaCnt_q;
   logic udmaPh_q, udmaTick, udma, hostAcc, strbRise;
   logic hostWrWord, hostRdWord, blkDone, lastBlk, issue;
   logic fInReady, fOutValid, fInValid, fOutReady;
   logic [15:0] fInData, fOutData;
   logic multEn_q;
   logic [4:0] blkSize_q;

   // Map an opcode onto the command kinds this block runs
   function automatic atas_kind_e kindOf(input logic [7:0] c);
      if (c == RD_DMA_OP) kindOf = K_RDMA;
      else if (c == WR_DMA_OP) kindOf = K_WDMA;
      else if (c == `ATAS_OP_RD_MULT) kindOf = K_RMULT;
      else if (c == `ATAS_OP_WR_MULT) kindOf = K_WMULT;
      else if (c == `ATAS_OP_SET_MULT) kindOf = K_SETM;
      else if (c == `ATAS_OP_WR_BUF) kindOf = K_WBUF;
      else if (c[7:2] == WR_SEC_OP[7:2] || c == `ATAS_OP_WR_VFY) kindOf = K_WSEC;
      else kindOf = K_BAD;
   endfunction : kindOf

   // Sectors in the next block; the min() yields the remainder block
   function automatic logic [8:0] blockLen(input atas_kind_e k, input logic [8:0] rem,
                                           input logic [4:0] bs);
      if (k == K_RMULT || k == K_WMULT) blockLen = (rem > {4'h0, bs}) ? {4'h0, bs} : rem;
      else if (k == K_RDMA || k == K_WDMA) blockLen = rem;
      else blockLen = 9'h001;
   endfunction : blockLen

   // ****************************************
   // Pin synchronisers and strobe edges
   // ****************************************
   assign rst = srst || softReset;
   assign kindNow = kindOf(cmdCode);
   assign blkN = blockLen(kind_q, remain_q, blkSize_q);

   // Strobe, acknowledge and data bus are all asynchronous to clk
   always_ff @(posedge clk) begin
      if (rst) begin
         pinS1_q <= 18'h30000;
         pinS2_q <= 18'h30000;
      end else begin
         pinS1_q <= {hostStrobeN, dmackN, ddIn};
         pinS2_q <= pinS1_q;
      end
   end

   // Host cycles complete on the rising edge of the active-low strobe
   assign strbRise = pinS2_q[17] && !strbPrev_q;
   assign hostAcc = dma_q ? !pinS2_q[16] : 1'b1;
   assign udma = udmaMode && dma_q && readDir_q;
   assign udmaTick = udmaCnt_q == `ATAS_UDMA_DIV - 4'h1;
   assign hostWrWord = state_q == ST_XFER && !readDir_q && hostAcc && strbRise
                       && hostWords_q != '0;
   assign hostRdWord = state_q == ST_XFER && readDir_q && fOutValid && hostWords_q != '0
                       && (udma ? (udmaTick && !udmaPh_q && !pinS2_q[16])
                                : (hostAcc && strbRise));

   // ****************************************
   // Data buffer steering
   // ****************************************
   assign fInData = readDir_q ? mediaRdData : pinS2_q[15:0];
   assign fInValid = readDir_q ? (mediaRdValid && mActive_q) : hostWrWord;
   assign fOutReady = readDir_q ? hostRdWord : (mediaWrReady && mActive_q);

   atas_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .srst(rst),
      .flush(state_q == ST_CHECK),
      .inData(fInData),
      .inValid(fInValid),
      .inReady(fInReady),
      .outData(fOutData),
      .outValid(fOutValid),
      .outReady(fOutReady)
   );
   assign mediaRdReady = fInReady;
   assign mediaWrData = fOutData;
   assign mediaWrValid = fOutValid;

   // ****************************************
   // Command sequencer
   // ****************************************
   // A block ends when the host has moved all words, or the media is drained
   assign blkDone = (state_q == ST_XFER && readDir_q
                     && (hostWords_q == '0 || (stop_q && !mActive_q && !fOutValid)))
                    || (state_q == ST_MEDIA && reqLeft_q == '0 && !mActive_q);
   assign lastBlk = remain_q == '0 || stop_q || errF_q;
   assign issue = (state_q == ST_XFER || state_q == ST_MEDIA) && !mActive_q
                  && reqLeft_q != '0 && !stop_q && !mediaReq;

   // Main control: decode, block setup, media requests and word counts
   always_ff @(posedge clk) begin
      irqEvt_q <= 1'b0;
      mediaReq <= 1'b0;
      if (rst) begin
         state_q <= ST_IDLE;
         kind_q <= K_BAD;
         multEn_q <= 1'b0; // R09
         blkSize_q <= 5'h00;
         {long_q, vfy_q, readDir_q, dma_q, stop_q, errF_q, abrt_q, mActive_q} <= 8'h00;
         cnt_q <= 8'h00;
         remain_q <= 9'h000;
         reqLeft_q <= 9'h000;
         mWords_q <= 9'h000;
         hostWords_q <= 17'h00000;
         curAddr_q <= '0;
         taskAddr <= '0;
         mediaAddr <= '0;
         mediaCmd <= '0;
      end else begin
         if (hostWrWord || hostRdWord) begin
            hostWords_q <= hostWords_q - 17'h00001;
         end
         // Issue the next sector of the block to the media engine
         if (issue) begin
            mediaReq <= 1'b1;
            mediaAddr <= curAddr_q;
            mActive_q <= 1'b1;
            reqLeft_q <= reqLeft_q - 9'h001;
            mWords_q <= `ATAS_SECT_WORDS;
         end
         if (readDir_q && mediaRdValid && fInReady && mActive_q) begin
            mWords_q <= mWords_q - 9'h001;
            mActive_q <= mWords_q != 9'h001;
         end
         // Sector outcome: address names the last good or the failing sector
         if (mediaStat && mActive_q) begin
            taskAddr <= curAddr_q; // R15 R16
            if (mediaErr) begin
               errF_q <= 1'b1; // R07 R18
               if (!readDir_q || dma_q) begin
                  stop_q <= 1'b1; // R03 R16 R21
                  mActive_q <= 1'b0;
               end
            end else begin
               curAddr_q <= curAddr_q + 1'b1;
               if (!readDir_q) begin
                  mActive_q <= 1'b0;
               end
            end
         end
         case (state_q)
            ST_IDLE: begin
               if (cmdWrite) begin
                  kind_q <= kindNow;
                  cnt_q <= cmdCount;
                  long_q <= cmdCode[`ATAS_LONG_BIT];
                  vfy_q <= cmdCode == `ATAS_OP_WR_VFY;
                  readDir_q <= kindNow == K_RDMA || kindNow == K_RMULT;
                  dma_q <= kindNow == K_RDMA || kindNow == K_WDMA;
                  remain_q <= (cmdCount == 8'h00) ? `ATAS_SECT_ZERO : {1'b0, cmdCount}; // R12
                  curAddr_q <= cmdAddr;
                  {stop_q, errF_q, abrt_q, mActive_q} <= 4'h0;
                  state_q <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               // Long mode only for single sector writes; ignored elsewhere
               mediaCmd.longMode <= long_q && kind_q == K_WSEC; // R04 R17 R20
               mediaCmd.op <= readDir_q ? MOP_READ : (kind_q == K_WBUF) ? MOP_BUFFER
                              : vfy_q ? MOP_VERIFY : MOP_WRITE; // R18
               case (kind_q)
                  K_SETM: begin
                     state_q <= ST_DONE;
                     if (cnt_q == 8'h00) begin
                        multEn_q <= 1'b0; // R08
                     end else if (cnt_q >= `ATAS_BLK_MIN && cnt_q <= `ATAS_BLK_MAX
                                  && (cnt_q & (cnt_q - 8'h01)) == 8'h00) begin
                        multEn_q <= 1'b1; // R10
                        blkSize_q <= cnt_q[4:0];
                     end else begin
                        multEn_q <= 1'b0; // R11
                        abrt_q <= 1'b1;
                     end
                  end
                  K_BAD: begin
                     abrt_q <= 1'b1;
                     state_q <= ST_DONE;
                  end
                  default: begin
                     if ((kind_q == K_RMULT || kind_q == K_WMULT) && !multEn_q) begin
                        abrt_q <= 1'b1; // R06
                        state_q <= ST_DONE;
                     end else begin
                        // First block: no interrupt for single sector writes
                        irqEvt_q <= kind_q == K_WMULT || kind_q == K_WBUF
                                    || kind_q == K_RMULT; // R13 R19 R22
                        reqLeft_q <= blkN; // R05
                        hostWords_q <= 17'(blkN) << `ATAS_WORDS_LOG2; // R19
                        remain_q <= remain_q - blkN;
                        state_q <= ST_XFER;
                     end
                  end
               endcase
            end
            ST_XFER: begin
               if (stop_q && !readDir_q) begin
                  state_q <= ST_DONE;
               end else if (!readDir_q && hostWords_q == '0) begin
                  state_q <= ST_MEDIA; // R14
               end
            end
            ST_MEDIA: begin
               if (stop_q) begin
                  state_q <= ST_DONE; // R21
               end
            end
            ST_DONE: begin
               // DMA and errors interrupt once here; read multiple did per block
               irqEvt_q <= abrt_q || errF_q || !(kind_q == K_RMULT || kind_q == K_WBUF); // R01
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
         // Next block opens with DRQ and, unless DMA, an interrupt
         if (blkDone) begin
            if (lastBlk) begin
               state_q <= ST_DONE;
            end else begin
               irqEvt_q <= !dma_q; // R04 R15 R22
               reqLeft_q <= blkN; // R05
               hostWords_q <= 17'(blkN) << `ATAS_WORDS_LOG2;
               remain_q <= remain_q - blkN;
               state_q <= ST_XFER;
            end
         end
      end
   end

   // ****************************************
   // Status, interrupt and host pins
   // ****************************************
   assign multEnabled = multEn_q;
   assign blockSize = blkSize_q;

   // Status follows state by one cycle; write multiple is busy at once
   always_ff @(posedge clk) begin
      if (rst) begin
         status <= '0;
      end else begin
         status.bsy <= state_q == ST_CHECK || state_q == ST_MEDIA; // R14 R20
         status.drq <= state_q == ST_XFER; // R13
         status.err <= errF_q || abrt_q;
         status.abrt <= abrt_q;
      end
   end

   // A new event wins over a clear arriving in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else if (irqEvt_q) begin
         irq <= 1'b1;
      end else if (statusRead || cmdWrite) begin
         irq <= 1'b0; // R23
      end
   end

   // Data bus, DMA request and data-in strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         strbPrev_q <= 1'b1;
         udmaCnt_q <= 4'h0;
         udmaPh_q <= 1'b0;
         ddOut <= 16'h0000;
         ddOe <= 1'b0;
         dmarq <= 1'b0;
         dStrobe <= 1'b1;
      end else begin
         strbPrev_q <= pinS2_q[17];
         udmaCnt_q <= udmaTick ? 4'h0 : udmaCnt_q + 4'h1;
         // Request only when the buffer can take or give a word
         dmarq <= state_q == ST_XFER && dma_q && hostWords_q != '0
                  && (readDir_q ? fOutValid : fInReady); // R01
         ddOe <= state_q == ST_XFER && readDir_q
                 && (udma ? !pinS2_q[16] : (hostAcc && !pinS2_q[17]));
         if (udma) begin
            if (hostRdWord) begin
               ddOut <= fOutData; // R02
               udmaPh_q <= 1'b1;
            end else if (udmaTick && udmaPh_q) begin
               dStrobe <= !dStrobe; // R02
               udmaPh_q <= 1'b0;
            end
         end else begin
            ddOut <= fOutData;
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_setm_zero;
      @(posedge clk) disable iff (rst)
      (state_q == ST_CHECK && kind_q == K_SETM && cnt_q == 8'h00) |=> !multEn_q && !abrt_q;
   endproperty
   a_setm_zero: assert property (p_setm_zero) else $error("zero size not disabled"); // R08

   property p_setm_ok;
      @(posedge clk) disable iff (rst)
      (state_q == ST_CHECK && kind_q == K_SETM && cnt_q inside {8'h02, 8'h04, 8'h08, 8'h10})
      |=> multEn_q && blkSize_q == $past(cnt_q[4:0]) ##2 !status.abrt;
   endproperty
   a_setm_ok: assert property (p_setm_ok) else $error("valid size not taken"); // R10

   property p_setm_bad;
      @(posedge clk) disable iff (rst)
      (state_q == ST_CHECK && kind_q == K_SETM && cnt_q != 8'h00
       && !(cnt_q inside {8'h02, 8'h04, 8'h08, 8'h10})) |=> abrt_q && !multEn_q ##2 status.abrt;
   endproperty
   a_setm_bad: assert property (p_setm_bad) else $error("bad size not aborted"); // R11

   property p_mult_off;
      @(posedge clk) disable iff (rst)
      (state_q == ST_CHECK && kind_q inside {K_RMULT, K_WMULT} && !multEn_q)
      |=> state_q == ST_DONE && abrt_q ##1 irqEvt_q;
   endproperty
   a_mult_off: assert property (p_mult_off) else $error("disabled multiple ran"); // R06

   property p_reset_off;
      @(posedge clk) $fell(rst) |-> !multEn_q;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("multiple on after reset"); // R09

   property p_first_fill;
      @(posedge clk) disable iff (rst)
      (state_q == ST_CHECK && kind_q == K_WSEC) |=> !irqEvt_q ##1 status.drq;
   endproperty
   a_first_fill: assert property (p_first_fill) else $error("first fill interrupted"); // R13

   property p_dma_irq;
      @(posedge clk) disable iff (rst)
      (dma_q && irqEvt_q) |-> $past(state_q) == ST_DONE;
   endproperty
   a_dma_irq: assert property (p_dma_irq) else $error("DMA early interrupt"); // R01

   property p_wr_stop;
      @(posedge clk) disable iff (rst)
      (mediaStat && mediaErr && mActive_q && !readDir_q) |=> !mediaReq [*2] ##0 state_q == ST_DONE;
   endproperty
   a_wr_stop: assert property (p_wr_stop) else $error("write went on after error"); // R16

   property p_rd_stop;
      @(posedge clk) disable iff (rst)
      (mediaStat && mediaErr && mActive_q && readDir_q && dma_q) |=> stop_q && !mediaReq [*3];
   endproperty
   a_rd_stop: assert property (p_rd_stop) else $error("failing sector requested on"); // R03

   property p_udma;
      @(posedge clk) disable iff (rst)
      $changed(dStrobe) |-> $stable(ddOut) && $past(udmaPh_q);
   endproperty
   a_udma: assert property (p_udma) else $error("strobe moved with data"); // R02

   property p_wmult_irq;
      @(posedge clk) disable iff (rst)
      ($rose(state_q == ST_XFER) && kind_q == K_WMULT) |-> irqEvt_q ##1 irq;
   endproperty
   a_wmult_irq: assert property (p_wmult_irq) else $error("block without interrupt"); // R22
endmodule : atas_sequencer

// File: tb/atas_host_model.sv
`timescale 1ns/10ps
// ****************************************
// Host adapter driving programmed writes
// ****************************************
module atas_host_model (
   input wire logic go,
   input wire logic [15:0] seed,
   output logic hostStrobeN,
   output logic [15:0] ddIn
);
   // Idle state: strobe high, bus quiet
   initial begin
      hostStrobeN = 1'b1;
      ddIn = 16'h0000;
   end
   // One sector of words, 125 ns per strobe cycle, PIO only
   always @(posedge go) begin
      for (int i = 0; i < 256; i++) begin
         ddIn = seed + 16'(i);
         #31.25 hostStrobeN = 1'b0;
         #62.5 hostStrobeN = 1'b1;
         // Hold past the sampling delay, then show the inverse: a released bus keeps no value
         #15.6 ddIn = ~ddIn;
         #15.65;
      end
   end
endmodule : atas_host_model

// File: tb/ata_data_transfer_command_sequencer_tb_top.sv
`timescale 1ns/10ps
module ata_data_transfer_command_sequencer_tb_top;
   import atas_pkg::*;
   logic clk, srst, softReset, cmdWrite, statusRead, go, mediaStat, mediaErr, errNext;
   logic [7:0] cmdCode, cmdCount;
   logic [27:0] taskAddr, mediaAddr, cmdAddr;
   logic [15:0] ddIn, ddOut, mediaWrData, firstWord, seed;
   logic hostStrobeN, ddOe, dmarq, dStrobe, multEnabled, irq, mediaReq, mediaRdReady;
   logic mediaWrValid, mediaWrReady;
   logic [4:0] blockSize;
   atas_stat_s status;
   atas_mreq_s mediaCmd;
   int err_count, cmp_count, wrCnt;
   // Set Multiple rows: count, enabled, size, aborted
   logic [14:0] rows [7] = '{{8'h00, 1'b0, 5'h00, 1'b0}, {8'h02, 1'b1, 5'h02, 1'b0},
      {8'h04, 1'b1, 5'h04, 1'b0}, {8'h08, 1'b1, 5'h08, 1'b0}, {8'h10, 1'b1, 5'h10, 1'b0},
      {8'h03, 1'b0, 5'h10, 1'b1}, {8'h11, 1'b0, 5'h10, 1'b1}};
   atas_sequencer #(.RD_DMA_OP(8'hC8), .WR_DMA_OP(8'hCA), .WR_SEC_OP(8'h30)) dut_u (
      .clk(clk), .srst(srst), .softReset(softReset), .cmdWrite(cmdWrite),
      .cmdCode(cmdCode), .cmdCount(cmdCount), .cmdAddr(cmdAddr),
      .statusRead(statusRead), .udmaMode(1'b0), .hostStrobeN(hostStrobeN),
      .dmackN(1'b1), .ddIn(ddIn), .ddOut(ddOut), .ddOe(ddOe), .dmarq(dmarq),
      .dStrobe(dStrobe), .status(status), .multEnabled(multEnabled),
      .blockSize(blockSize), .irq(irq), .taskAddr(taskAddr), .mediaReq(mediaReq),
      .mediaCmd(mediaCmd), .mediaAddr(mediaAddr), .mediaStat(mediaStat),
      .mediaErr(mediaErr), .mediaRdData(16'h0000), .mediaRdValid(1'b0),
      .mediaRdReady(mediaRdReady), .mediaWrData(mediaWrData), .mediaWrValid(mediaWrValid),
      .mediaWrReady(mediaWrReady));
   atas_host_model host_u (.go(go), .seed(seed), .hostStrobeN(hostStrobeN), .ddIn(ddIn));
   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Media side: takes one sector of words at half rate, then reports its outcome
   always @(posedge clk) begin
      mediaStat <= 1'b0;
      mediaWrReady <= ~mediaWrReady;
      if (mediaWrValid === 1'b1 && mediaWrReady) begin
         wrCnt <= wrCnt + 1;
         if (wrCnt == 0) firstWord <= mediaWrData;
      end
      if (wrCnt == 256) begin
         mediaStat <= 1'b1;
         mediaErr <= errNext;
         wrCnt <= 0;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic cmd(input logic [7:0] c, input logic [7:0] n);
      cmdCode = c;
      cmdCount = n;
      cmdWrite = 1'b1;
      @(posedge clk);
      #1 cmdWrite = 1'b0;
   endtask : cmd
   // Bounded wait for idle, then let the interrupt land
   task automatic wait_idle();
      int i;
      repeat (4) @(posedge clk);
      for (i = 0; i < 20000 && (status.bsy !== 1'b0 || status.drq !== 1'b0); i++)
         @(posedge clk);
      if (i == 20000) err_count++;
      repeat (2) @(posedge clk);
      #1;
   endtask : wait_idle
   task automatic ack();
      statusRead = 1'b1;
      @(posedge clk);
      #1 statusRead = 1'b0;
      @(posedge clk);
      #1;
   endtask : ack
   // One sector written through the buffer, with or without a media fault
   task automatic wsec(input logic [7:0] op, input logic bad);
      int i;
      errNext = bad;
      seed = {op, 8'hC0};
      cmdAddr = {20'h00001, op};
      cmd(op, 8'h01);
      repeat (4) @(posedge clk);
      #1 check(status.drq, 1'b1);
      check(irq, 1'b0);
      go = 1'b1;
      for (i = 0; i < 20000 && status.bsy !== 1'b1; i++) @(posedge clk);
      if (i == 20000) err_count++;
      #1 check(status.drq, 1'b0);
      go = 1'b0;
      wait_idle();
      check(firstWord, seed);
      check(mediaCmd.op, (op == 8'h3C) ? MOP_VERIFY : MOP_WRITE);
      check(mediaCmd.longMode, op[1]);
      check(taskAddr, cmdAddr);
      check(status.err, bad);
      check(irq, 1'b1);
      ack();
      $display("test write sector done");
   endtask : wsec
   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results
   // Watchdog sized for two sector writes plus margin
   initial begin
      #300000;
      err_count++;
      results();
   end
   initial begin
      {srst, softReset, cmdWrite, statusRead, go, errNext, mediaErr, mediaWrReady} = 8'h80;
      {cmdCode, cmdCount, wrCnt, cmdAddr, seed} = '0;
      repeat (2) @(posedge clk);
      #1 srst = 1'b0;
      check({multEnabled, blockSize, dStrobe, irq}, {1'b0, 5'h00, 1'b1, 1'b0});
      cmd(8'hC4, 8'h04);
      wait_idle();
      check(status.abrt, 1'b1);
      ack();
      $display("test reset done");
      foreach (rows[k]) begin
         cmd(8'hC6, rows[k][14:7]);
         wait_idle();
         check({multEnabled, blockSize, status.abrt}, rows[k][6:0]);
         check(irq, 1'b1);
         ack();
         check(irq, 1'b0);
      end
      $display("test set multiple done");
      // Pending interrupt and block size must not survive a software reset
      cmd(8'hC6, 8'h08);
      wait_idle();
      check(multEnabled, 1'b1);
      softReset = 1'b1;
      @(posedge clk);
      #1 softReset = 1'b0;
      check({multEnabled, blockSize, irq}, 7'h00);
      cmd(8'hC5, 8'h04);
      wait_idle();
      check(status.abrt, 1'b1);
      ack();
      $display("test disabled write multiple done");
      wsec(8'h32, 1'b0);
      wsec(8'h3C, 1'b1);
      results();
   end
endmodule : ata_data_transfer_command_sequencer_tb_top
